// ### rtl/rxs_ctrl.sv
// receive control / transceiver interrupt enable / shutdown register block
// Operation
// RULE1: bits 7 and 5 read zero, write zero
// RULE2: bit 6 gates link-fail interrupt
// RULE3: bit 4 picks standby or shutdown
// RULE4: test bit must be written zero
// RULE5: writing skip one advances read pointer; here only while the sequencer is idle, a skip bit written during a skip is ignored
// RULE6: skip reads one until done, ~200 ns
// RULE7: last packet skipped sets buffer empty
// RULE8: skip only after 4-byte header read; not checked here, a skip is taken whenever the sequencer is idle
// RULE9: no skip with 8 bytes left; not checked here, a skip is taken whenever the sequencer is idle
// RULE10: writing skip zero does nothing
// RULE11: bit 1 gates SQE interrupt
// RULE12: filter own frames in mode 11
// RULE13: reset clears every bit
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module rxs_ctrl (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic link_fail_i,
    input wire logic sig_quality_err_i,
    output logic link_fail_int_o,
    output logic sig_quality_err_int_o,
    input wire logic low_power_request_i,
    output logic standby_o,
    output logic shutdown_o,
    output logic chip_test_o,
    output logic rx_packet_skip_o,
    input wire logic last_packet_i,
    output logic rx_buffer_empty_set_o,
    input wire logic addr_match_mode_hi_i,
    input wire logic addr_match_mode_lo_i,
    input wire logic own_frame_i,
    output logic own_frame_discard_o,
    output logic irq_o
);
    rxs_pkg::rxs_bus_req_t req;
    rxs_pkg::rxs_state_s_t s_q;
    rxs_pkg::rxs_state_s_t s_d;
    logic [2:0] ev;

    // group bus signals into one carrier
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // read value of the control register; unused bits fixed at zero
    function automatic logic [7:0] ctrl_view(input rxs_pkg::rxs_state_s_t s);
        logic [7:0] v;
        v = 8'h00; // RULE1
        v[rxs_pkg::BIT_LKF_EN] = s.lkf_en;
        v[rxs_pkg::BIT_DEPTH] = s.depth;
        v[rxs_pkg::BIT_TEST] = s.test;
        v[rxs_pkg::BIT_SKIP] = (s.st == rxs_pkg::RXS_SKIP); // RULE6
        v[rxs_pkg::BIT_SQE_EN] = s.sqe_en;
        v[rxs_pkg::BIT_FILTER] = s.filter;
        return v;
    endfunction

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        s_d.skip_req = 1'b0;
        s_d.empty_set = 1'b0;
        // pins from the transceiver pass two flops before use
        s_d.lkf_sync = {s_q.lkf_sync[0], link_fail_i};
        s_d.sqe_sync = {s_q.sqe_sync[0], sig_quality_err_i};
        s_d.lkf_int = s_q.lkf_sync[1] & s_q.lkf_en; // RULE2
        s_d.sqe_int = s_q.sqe_sync[1] & s_q.sqe_en; // RULE11
        // skip sequencer: pointer pulse at start, counted completion
        case (s_q.st)
            rxs_pkg::RXS_IDLE: begin
                if (req.wr && req.addr == rxs_pkg::ADDR_CTRL && req.wdata[rxs_pkg::BIT_SKIP]) begin // RULE10
                    s_d.st = rxs_pkg::RXS_SKIP;
                    s_d.skip_req = 1'b1; // RULE5
                    s_d.cnt = rxs_pkg::SKIP_CYCLES - 5'h01;
                end
            end
            rxs_pkg::RXS_SKIP: begin
                if (s_q.cnt == 5'h00) begin
                    s_d.st = rxs_pkg::RXS_IDLE; // RULE6
                    s_d.empty_set = last_packet_i; // RULE7
                end else begin
                    s_d.cnt = s_q.cnt - 5'h01;
                end
            end
            default: s_d.st = rxs_pkg::RXS_IDLE;
        endcase
        // register writes; skip bit handled by the sequencer, bits 7/5 dropped
        if (req.wr) begin
            case (req.addr)
                rxs_pkg::ADDR_CTRL: begin
                    s_d.lkf_en = req.wdata[rxs_pkg::BIT_LKF_EN];
                    s_d.depth = req.wdata[rxs_pkg::BIT_DEPTH]; // RULE3
                    s_d.test = req.wdata[rxs_pkg::BIT_TEST]; // RULE4
                    s_d.sqe_en = req.wdata[rxs_pkg::BIT_SQE_EN];
                    s_d.filter = req.wdata[rxs_pkg::BIT_FILTER];
                end
                rxs_pkg::ADDR_INT_STATUS: s_d.irq_stat = s_q.irq_stat & ~req.wdata[2:0];
                rxs_pkg::ADDR_INT_MASK: s_d.irq_mask = req.wdata[2:0];
                default: ;
            endcase
        end
        // sticky events win over a simultaneous clear
        s_d.irq_stat = s_d.irq_stat | ev;
        // read data appear in the cycle after the strobe; unmapped reads zero
        if (req.rd) begin
            case (req.addr)
                rxs_pkg::ADDR_CTRL: s_d.rdata = ctrl_view(s_q);
                rxs_pkg::ADDR_INT_STATUS: s_d.rdata = {5'h00, s_q.irq_stat};
                rxs_pkg::ADDR_INT_MASK: s_d.rdata = {5'h00, s_q.irq_mask};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // events: gated link fail, gated sqe, skip completion (rising edges)
    // built from registered state only, so no loop through the next-state process
    always_comb begin
        ev = 3'h0;
        ev[rxs_pkg::IRQ_LKF] = (s_q.lkf_sync[1] & s_q.lkf_en) & ~s_q.lkf_int; // RULE2
        ev[rxs_pkg::IRQ_SQE] = (s_q.sqe_sync[1] & s_q.sqe_en) & ~s_q.sqe_int; // RULE11
        ev[rxs_pkg::IRQ_SKIP_DONE] = (s_q.st == rxs_pkg::RXS_SKIP) && (s_q.cnt == 5'h00);
    end

    // single state register; all fields zero at reset
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0; // RULE13
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign rdata_o = s_q.rdata;
    assign link_fail_int_o = s_q.lkf_int;
    assign sig_quality_err_int_o = s_q.sqe_int;
    assign standby_o = low_power_request_i & ~s_q.depth; // RULE3
    assign shutdown_o = low_power_request_i & s_q.depth; // RULE3
    assign chip_test_o = s_q.test;
    assign rx_packet_skip_o = s_q.skip_req; // RULE5
    assign rx_buffer_empty_set_o = s_q.empty_set; // RULE7
    // own frames dropped only in promiscuous match mode
    assign own_frame_discard_o = s_q.filter & own_frame_i
        & ({addr_match_mode_hi_i, addr_match_mode_lo_i} == rxs_pkg::AM_PROMISC); // RULE12
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
endmodule
`default_nettype wire

// ### rtl/rxs_pkg.sv
// package for the receive control / transceiver interrupt enable / shutdown register
package rxs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // skip completion time, as printed, in ns
    localparam int unsigned SKIP_TIME_NS = 200;
    localparam int unsigned SKIP_CYCLES_INT = (SKIP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (SKIP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [4:0] SKIP_CYCLES = SKIP_CYCLES_INT[4:0];

    // register map (offsets chosen locally)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_INT_STATUS = 4'h1;
    localparam logic [3:0] ADDR_INT_MASK = 4'h2;

    // control register field positions
    localparam int unsigned BIT_LKF_EN = 6;
    localparam int unsigned BIT_DEPTH = 4;
    localparam int unsigned BIT_TEST = 3;
    localparam int unsigned BIT_SKIP = 2;
    localparam int unsigned BIT_SQE_EN = 1;
    localparam int unsigned BIT_FILTER = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // interrupt status fields
    localparam int unsigned IRQ_LKF = 0;
    localparam int unsigned IRQ_SQE = 1;
    localparam int unsigned IRQ_SKIP_DONE = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    localparam logic [1:0] AM_PROMISC = 2'h3;

    typedef enum logic [0:0] {
        RXS_IDLE = 1'b0,
        RXS_SKIP = 1'b1
    } rxs_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rxs_bus_req_t;

    typedef struct packed {
        rxs_state_t st;
        logic lkf_en;
        logic depth;
        logic test;
        logic sqe_en;
        logic filter;
        logic [4:0] cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [7:0] rdata;
        logic skip_req;
        logic empty_set;
        logic [1:0] lkf_sync;
        logic [1:0] sqe_sync;
        logic lkf_int;
        logic sqe_int;
    } rxs_state_s_t;
endpackage

// ### tb/rxs_ctrl_chk.sv
// assertion checker for the control register block
`timescale 1ns/10ps
`default_nettype none
module rxs_ctrl_chk (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic link_fail_i,
    input wire logic sig_quality_err_i,
    input wire logic link_fail_int_o,
    input wire logic sig_quality_err_int_o,
    input wire logic low_power_request_i,
    input wire logic standby_o,
    input wire logic shutdown_o,
    input wire logic rx_packet_skip_o,
    input wire logic rx_buffer_empty_set_o,
    input wire logic addr_match_mode_hi_i,
    input wire logic addr_match_mode_lo_i,
    input wire logic own_frame_i,
    input wire logic own_frame_discard_o
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_unused_zero: assert property ($past(rd_i && addr_i == 4'h0) |-> !rdata_o[7] && !rdata_o[5]) else $error("bad");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
    a_lkf_gate: assert property (link_fail_int_o |-> $past(link_fail_i, 3)) else $error("link int without cause");
    a_sqe_gate: assert property (sig_quality_err_int_o |-> $past(sig_quality_err_i, 3)) else $error("sqe int bad");
    a_depth_pick: assert property (low_power_request_i |-> standby_o ^ shutdown_o) else $error("power state bad");
    a_skip_cause: assert property (rx_packet_skip_o |-> $past(wr_i && addr_i == 4'h0 && wdata_i[2])) else $error("x");
    a_skip_busy: assert property (rx_packet_skip_o |=> !rx_packet_skip_o [*8]) else $error("skip while busy");
    a_empty_time: assert property (rx_buffer_empty_set_o |-> $past(rx_packet_skip_o, 20)) else $error("empty mistimed");
    a_own_filter: assert property (own_frame_discard_o |-> own_frame_i && addr_match_mode_hi_i && addr_match_mode_lo_i)
        else $error("discard outside mode");
endmodule
bind rxs_ctrl rxs_ctrl_chk chk (.*);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the control register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
    logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, link_fail_i = 0, sig_quality_err_i = 0;
    logic low_power_request_i = 0, last_packet_i = 0, addr_match_mode_hi_i = 0, addr_match_mode_lo_i = 0, own_frame_i = 0;
    logic [3:0] addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o;
    logic link_fail_int_o, sig_quality_err_int_o, standby_o, shutdown_o, chip_test_o, rx_packet_skip_o;
    logic rx_buffer_empty_set_o, own_frame_discard_o, irq_o;
    int bad_count = 0, comparisons = 0, np = 0, ne = 0, m;
    rxs_ctrl uut (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .link_fail_i(link_fail_i),
        .sig_quality_err_i(sig_quality_err_i),
        .link_fail_int_o(link_fail_int_o),
        .sig_quality_err_int_o(sig_quality_err_int_o),
        .low_power_request_i(low_power_request_i),
        .standby_o(standby_o),
        .shutdown_o(shutdown_o),
        .chip_test_o(chip_test_o),
        .rx_packet_skip_o(rx_packet_skip_o),
        .last_packet_i(last_packet_i),
        .rx_buffer_empty_set_o(rx_buffer_empty_set_o),
        .addr_match_mode_hi_i(addr_match_mode_hi_i),
        .addr_match_mode_lo_i(addr_match_mode_lo_i),
        .own_frame_i(own_frame_i),
        .own_frame_discard_o(own_frame_discard_o),
        .irq_o(irq_o)
    );
    always #5 ref_clk_i = ~ref_clk_i;
    // count pulses on the falling edge, clear of the launching edge
    always @(negedge ref_clk_i) begin
        np += rx_packet_skip_o;
        ne += rx_buffer_empty_set_o;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(71));
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h00);
        $display("test reset done");
        // random field values; unused bits written too, test and skip bits kept clear
        for (int i = 0; i < 8; i++) begin
            m = $urandom & 32'hF3;
            {link_fail_i, sig_quality_err_i, low_power_request_i, own_frame_i} <= 4'($urandom);
            {addr_match_mode_hi_i, addr_match_mode_lo_i} <= 2'($urandom | i);
            wr(4'h0, 8'(m));
            rd(4'h0, 8'(m & 8'h53));
            `CHK(chip_test_o, 1'b0)
            `CHK(shutdown_o, low_power_request_i & m[4])
            `CHK(standby_o, low_power_request_i & ~m[4])
            `CHK(link_fail_int_o, link_fail_i & m[6])
            `CHK(sig_quality_err_int_o, sig_quality_err_i & m[1])
            `CHK(own_frame_discard_o, own_frame_i & addr_match_mode_hi_i & addr_match_mode_lo_i & m[0])
        end
        $display("test fields done");
        link_fail_i <= 1'b0;
        sig_quality_err_i <= 1'b0;
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h07);
        wr(4'h0, 8'h42);
        link_fail_i <= 1'b1;
        rd(4'h1, 8'h00);
        rd(4'h1, 8'h01);
        `CHK(irq_o, 1'b0)
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h01);
        `CHK(irq_o, 1'b1)
        wr(4'h1, 8'h01);
        rd(4'h1, 8'h00);
        `CHK(irq_o, 1'b0)
        $display("test irq done");
        // skip with last packet, a retry while busy, then one without
        np = 0;
        ne = 0;
        last_packet_i <= 1'b1;
        wr(4'h0, 8'h00);
        // header taken as read and more than 8 bytes left before each skip
        wr(4'h0, 8'h04);
        rd(4'h0, 8'h04);
        wr(4'h0, 8'h04);
        repeat (22) @(posedge ref_clk_i);
        rd(4'h0, 8'h00);
        `CHK(np, 1)
        `CHK(ne, 1)
        rd(4'h1, 8'h04);
        last_packet_i <= 1'b0;
        wr(4'h0, 8'h04);
        repeat (24) @(posedge ref_clk_i);
        #1 `CHK(np, 2)
        `CHK(ne, 1)
        $display("test skip done");
        close_out();
    end
    initial begin
        repeat (2000) @(posedge ref_clk_i);
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
